// *** include/sensor_bank_pkg.sv ***
// shared constants, register map and state types for the sensor serial link
package sensor_bank_pkg;
  // register bank geometry
  localparam int NREG = 26;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8; // ninth clock of every byte
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [4:0] NO_REG = 5'h1F; // lookup miss
  // identity value, arbitrary neutral code
  localparam logic [15:0] CHIP_ID = 16'hA5C3;
  // slave address, arbitrary default
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
  // serial clock timing: one bit is four quarters
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  // printed offsets
  localparam logic [7:0] REG_OFF [NREG] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09,
    8'h0B, 8'h0C, 8'h0D, 8'h1E, 8'h20, 8'h2B, 8'h2C, 8'h2D, 8'h2E,
    8'h35, 8'h5F, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'hF1};
  // defaults
  localparam logic [15:0] REG_RST [NREG] = '{
    16'h0000, 16'h000C, 16'h0014, 16'h03FF, 16'h04FF, 16'h0009,
    16'h0019, 16'h0002, 16'h0419, 16'h0000, 16'h0000, 16'h0000,
    16'h8000, 16'h1104, 16'h0008, 16'h0008, 16'h0008, 16'h0008,
    16'h0008, 16'h0904, 16'h0000, 16'h0000, 16'h0498, 16'h0000,
    16'h0000, 16'h0001};
  // programmable bit positions
  localparam logic [15:0] REG_WM [NREG] = '{
    16'h0000, 16'h07FF, 16'h07FF, 16'h07FF, 16'h07FF, 16'h07FF,
    16'h07FF, 16'h0043, 16'h3FFF, 16'h0001, 16'h07FF, 16'h0001,
    16'h0F3C, 16'hC699, 16'h007F, 16'h007F, 16'h007F, 16'h007F,
    16'h007F, 16'h0FFF, 16'h01FF, 16'h01FF, 16'h9807, 16'h01FF,
    16'h01FF, 16'h0003};
  // bits that always read as one
  localparam logic [15:0] REG_FIX [NREG] = '{
    CHIP_ID, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h8000, 16'h1104, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0498, 16'h0000,
    16'h0000, 16'h0000};
  // calibration targets selected by cal_sel
  localparam logic [7:0] CAL_OFF [4] = '{8'h60, 8'h61, 8'h63, 8'h64};
  // host software registers
  localparam logic [1:0] HOST_CMD = 2'h0;
  localparam logic [1:0] HOST_WDATA = 2'h1;
  localparam logic [1:0] HOST_STATUS = 2'h2;
  localparam logic [1:0] HOST_RDATA = 2'h3;
  localparam int CMD_GO_WRITE = 0;
  localparam int CMD_GO_READ = 1;
  // host step indices of the final stop and of the last read byte
  localparam logic [3:0] WR_STOP_STEP = 4'h5;
  localparam logic [3:0] RD_STOP_STEP = 4'h7;
  localparam logic [3:0] RD_LAST_STEP = 4'h6;

  typedef enum {D_IDLE, D_RX, D_ACK, D_TX, D_MACK} dev_state_t;
  typedef enum logic [1:0] {K_DEV, K_REG, K_HI, K_LO} byte_kind_t;
  typedef enum {OP_START, OP_TX, OP_RX, OP_STOP} host_op_t;

  // map a register address to its bank slot, NO_REG when unmapped
  function automatic logic [4:0] find_reg(input logic [7:0] a);
    find_reg = NO_REG;
    for (int i = 0; i < NREG; i++) begin
      if (REG_OFF[i] == a) begin
        find_reg = 5'(i);
      end
    end
  endfunction : find_reg
endpackage : sensor_bank_pkg

// *** include/sensor_link_if.sv ***
// two-wire link between bus master and sensor register bank
`timescale 1ns/10ps
`default_nettype none
interface sensor_link_if;
  logic scl; // serial clock, master driven
  logic host_sda_out; // master data level when enabled
  logic host_sda_oe; // master pulls the line
  logic dev_sda_out; // device data level when enabled
  logic dev_sda_oe; // device pulls the line
  logic serial_data_line; // resolved open-drain line, pulled up
  // open drain: any enabled low drive wins, otherwise pull-up
  assign serial_data_line = !((host_sda_oe && !host_sda_out) ||
                              (dev_sda_oe && !dev_sda_out));
  modport host (output scl, output host_sda_out, output host_sda_oe,
                input serial_data_line);
  modport device (input scl, input serial_data_line,
                  output dev_sda_out, output dev_sda_oe);
endinterface : sensor_link_if
`default_nettype wire

// *** logic/sensor_bus_master.sv ***
// two-wire bus master issuing single-word register writes and reads
`timescale 1ns/10ps
`default_nettype none
module sensor_bus_master #(
  parameter int QUARTER_CYC = sensor_bank_pkg::QUARTER_CYC,
  parameter logic [6:0] DEV_ADDR = sensor_bank_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  sensor_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata
);
  localparam int DW = $clog2(QUARTER_CYC + 1);
  typedef struct packed {
    logic busy; // transfer in progress
    logic rdm; // read transfer
    logic [3:0] step; // position in the op sequence
    logic [1:0] qtr; // quarter of the bit
    logic [DW-1:0] div; // quarter timer
    logic [3:0] bitn; // bit within a byte, 8 is the ack slot
    logic [7:0] regaddr; // target register
    logic [15:0] wword; // word to write
    logic [15:0] rword; // word read back
    logic nack; // device did not acknowledge
    logic scl; // serial clock out
    logic sda_oe; // pulling data low
    logic [15:0] rdata; // software read data
  } host_t;
  host_t q, next_q;
  logic sda_s; // synchronised data line

  two_flop_sync #(.W(1)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(link.serial_data_line),
    .q(sda_s)
  );

  // operation at each step of a write or a read
  function automatic sensor_bank_pkg::host_op_t op_at(input logic r,
                                                      input logic [3:0] s);
    op_at = sensor_bank_pkg::OP_TX;
    if (s == 4'h0 || (r && s == 4'h3)) begin
      op_at = sensor_bank_pkg::OP_START; // R15 repeated start
    end else if (r && (s == 4'h5 || s == sensor_bank_pkg::RD_LAST_STEP)) begin
      op_at = sensor_bank_pkg::OP_RX;
    end else if (s == (r ? sensor_bank_pkg::RD_STOP_STEP
                         : sensor_bank_pkg::WR_STOP_STEP)) begin
      op_at = sensor_bank_pkg::OP_STOP;
    end
  endfunction : op_at

  // byte sent at a transmit step
  function automatic logic [7:0] tx_byte(input host_t h);
    unique case (h.step)
      4'h1: tx_byte = {DEV_ADDR, 1'b0}; // R2 R14
      4'h2: tx_byte = h.regaddr; // R3
      4'h3: tx_byte = h.wword[15:8];
      4'h4: tx_byte = h.rdm ? {DEV_ADDR, 1'b1} : h.wword[7:0]; // R15
      default: tx_byte = 8'h00;
    endcase
  endfunction : tx_byte

  // sequencer, bit timing and software port
  always_comb begin
    sensor_bank_pkg::host_op_t op;
    logic [7:0] tb;
    op = op_at(q.rdm, q.step);
    tb = tx_byte(q);
    next_q = q;
    next_q.rdata = 16'h0000;
    if (rd) begin
      next_q.rdata = (addr == sensor_bank_pkg::HOST_RDATA) ? q.rword
                   : (addr == sensor_bank_pkg::HOST_STATUS)
                     ? {14'h0000, q.nack, q.busy} : 16'h0000;
    end
    if (wr && addr == sensor_bank_pkg::HOST_WDATA) begin
      next_q.wword = wdata;
    end
    if (!q.busy) begin
      // commands taken only while idle
      if (wr && addr == sensor_bank_pkg::HOST_CMD &&
          (wdata[sensor_bank_pkg::CMD_GO_WRITE] ||
           wdata[sensor_bank_pkg::CMD_GO_READ])) begin
        next_q.busy = 1'b1;
        next_q.rdm = !wdata[sensor_bank_pkg::CMD_GO_WRITE];
        next_q.regaddr = wdata[15:8];
        next_q.step = 4'h0;
        next_q.qtr = 2'h0;
        next_q.div = '0;
        next_q.bitn = 4'h0;
        next_q.nack = 1'b0;
        next_q.rword = 16'h0000;
      end
    end else if (q.div != DW'(QUARTER_CYC - 1)) begin
      next_q.div = q.div + 1'b1;
    end else begin
      next_q.div = '0;
      next_q.qtr = q.qtr + 2'h1;
      unique case (q.qtr)
        2'h0: begin
          // clock low: set up data
          unique case (op)
            sensor_bank_pkg::OP_START: next_q.sda_oe = 1'b0;
            sensor_bank_pkg::OP_STOP: next_q.sda_oe = 1'b1;
            sensor_bank_pkg::OP_TX: begin
              // ack slot released for the device
              next_q.sda_oe = (q.bitn != sensor_bank_pkg::ACK_SLOT)
                              && !tb[3'(sensor_bank_pkg::LAST_BIT - q.bitn)];
            end
            sensor_bank_pkg::OP_RX: begin
              // ack every byte but the last, which gets nack
              next_q.sda_oe = (q.bitn == sensor_bank_pkg::ACK_SLOT) &&
                  (q.step != sensor_bank_pkg::RD_LAST_STEP); // R1 R16
            end
          endcase
        end
        2'h1: next_q.scl = 1'b1;
        2'h2: begin
          // clock high: start/stop edge or sample
          if (op == sensor_bank_pkg::OP_START) begin
            next_q.sda_oe = 1'b1;
          end else if (op == sensor_bank_pkg::OP_STOP) begin
            next_q.sda_oe = 1'b0; // R7
          end else if (op == sensor_bank_pkg::OP_TX &&
                       q.bitn == sensor_bank_pkg::ACK_SLOT) begin
            next_q.nack = sda_s; // R4
          end else if (op == sensor_bank_pkg::OP_RX &&
                       q.bitn != sensor_bank_pkg::ACK_SLOT) begin
            next_q.rword = {q.rword[14:0], sda_s}; // R3
          end
        end
        2'h3: begin
          // end of bit: advance
          if (op != sensor_bank_pkg::OP_STOP) begin
            next_q.scl = 1'b0;
          end
          if (op == sensor_bank_pkg::OP_STOP) begin
            next_q.busy = 1'b0;
          end else if (op == sensor_bank_pkg::OP_START ||
                       q.bitn == sensor_bank_pkg::ACK_SLOT) begin
            next_q.bitn = 4'h0;
            next_q.step = q.step + 4'h1;
            if (q.nack) begin
              // refused byte: finish with a stop
              next_q.step = q.rdm ? sensor_bank_pkg::RD_STOP_STEP
                                  : sensor_bank_pkg::WR_STOP_STEP;
            end
          end else begin
            next_q.bitn = q.bitn + 4'h1;
          end
        end
      endcase
    end
  end

  // bus idles with both lines released high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.scl <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign link.scl = q.scl;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = q.sda_oe;
  assign rdata = q.rdata;
endmodule : sensor_bus_master
`default_nettype wire

// *** logic/sensor_serial_register_bank.sv ***
// sensor register bank reached as a slave on the two-wire link
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R1] master nack ends read, device releases
// [R2] start then write address, device acknowledges
// [R3] register address, then data high byte first
// [R4] acknowledge every received byte during writes
// [R5] high byte held, committed with low byte
// [R6] register address increments after each word
// [R7] start or stop returns to address recognition
// [R8] address zero reads fixed id, ignores writes
// [R9] first row bits 0-10, default twelve
// [R10] first column bits 0-10, default twenty, even; odd values are stored as written
// [R11] height minus one, default 1023, min two; smaller values are stored as written
// [R12] width minus one, default 1279, odd, min three; even and smaller values are stored as written
// [R13] calibration offsets reset zero, loaded internally
// [R14] address low bit selects read or write
// [R15] read: set address, restart, read-mode address
// [R16] transmitter releases, receiver pulls low to ack
// [R17] fixed bits read constant, writes ignored there
// [R18] unmapped reads zero, writes discarded
module sensor_serial_register_bank #(
  parameter logic [6:0] DEV_ADDR = sensor_bank_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  sensor_link_if.device link,
  input wire logic cal_write,
  input wire logic [1:0] cal_sel,
  input wire logic [8:0] cal_value,
  output logic [sensor_bank_pkg::NREG-1:0][15:0] config_regs,
  output logic busy
);
  typedef struct packed {
    sensor_bank_pkg::dev_state_t st; // byte level state
    sensor_bank_pkg::byte_kind_t kind; // meaning of next byte
    logic rd; // read-mode transfer
    logic [3:0] cnt; // bit counter within a byte
    logic [7:0] sh; // shift register, both directions
    logic [7:0] raddr; // auto-incrementing register pointer
    logic [7:0] hold; // high byte waiting for its low byte
    logic sda_oe; // pulling the data line low
    logic ps; // last sampled clock
    logic pd; // last sampled data
    logic busy; // inside a transfer, from a start until a stop, a foreign slave address or a master nack
    logic [sensor_bank_pkg::NREG-1:0][15:0] regs; // programmable bits
  } dev_t;
  dev_t q, next_q;

  logic [1:0] pins; // synchronised {clock, data}
  logic scl_s; // synchronised clock
  logic sda_s; // synchronised data line
  logic rise; // clock rising edge
  logic fall; // clock falling edge
  logic start_c; // start or repeated start
  logic stop_c; // stop

  // pins come from another domain, two flops first
  two_flop_sync #(.W(2)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({link.scl, link.serial_data_line}),
    .q(pins)
  );
  assign scl_s = pins[1];
  assign sda_s = pins[0];

  // value seen by the master, fixed bits merged in
  function automatic logic [15:0] read_word(input dev_t s,
                                            input logic [7:0] a);
    logic [4:0] i;
    i = sensor_bank_pkg::find_reg(a);
    read_word = 16'h0000; // R18
    if (i != sensor_bank_pkg::NO_REG) begin
      read_word = (s.regs[i] & sensor_bank_pkg::REG_WM[i])
                  | sensor_bank_pkg::REG_FIX[i]; // R17 R8
    end
  endfunction : read_word

  // line events from the synchronised copies
  always_comb begin
    rise = scl_s && !q.ps;
    fall = !scl_s && q.ps;
    start_c = scl_s && q.ps && q.pd && !sda_s;
    stop_c = scl_s && q.ps && !q.pd && sda_s;
  end

  // protocol engine and register file
  always_comb begin
    logic [4:0] wi;
    logic [4:0] ci;
    logic [15:0] word;
    wi = sensor_bank_pkg::find_reg(q.raddr);
    ci = sensor_bank_pkg::find_reg(sensor_bank_pkg::CAL_OFF[cal_sel]);
    word = read_word(q, q.raddr);
    next_q = q;
    next_q.ps = scl_s;
    next_q.pd = sda_s;
    if (stop_c) begin
      // stop: back to idle, line released
      next_q.st = sensor_bank_pkg::D_IDLE; // R7
      next_q.sda_oe = 1'b0;
    end else if (start_c) begin
      // start or repeated start: expect a slave address
      next_q.st = sensor_bank_pkg::D_RX; // R2 R7
      next_q.kind = sensor_bank_pkg::K_DEV;
      next_q.cnt = 4'h0;
      next_q.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        sensor_bank_pkg::D_IDLE: begin
          // wait for a start
          next_q.sda_oe = 1'b0;
        end
        sensor_bank_pkg::D_RX: begin
          if (rise && q.cnt != sensor_bank_pkg::ACK_SLOT) begin
            // msb first, sampled while clock high
            next_q.sh = {q.sh[6:0], sda_s};
            next_q.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == sensor_bank_pkg::ACK_SLOT) begin
            // byte complete: pull low for the acknowledge clock
            next_q.sda_oe = 1'b1; // R4 R16
            next_q.st = sensor_bank_pkg::D_ACK;
            next_q.cnt = 4'h0;
            unique case (q.kind)
              sensor_bank_pkg::K_DEV: begin
                if (q.sh[7:1] == DEV_ADDR) begin
                  next_q.rd = q.sh[0]; // R14
                  next_q.kind = q.sh[0] ? sensor_bank_pkg::K_HI
                                        : sensor_bank_pkg::K_REG; // R15
                end else begin
                  // not our address: stay off the line
                  next_q.sda_oe = 1'b0;
                  next_q.st = sensor_bank_pkg::D_IDLE;
                end
              end
              sensor_bank_pkg::K_REG: begin
                next_q.raddr = q.sh; // R3
                next_q.kind = sensor_bank_pkg::K_HI;
              end
              sensor_bank_pkg::K_HI: begin
                next_q.hold = q.sh; // R5
                next_q.kind = sensor_bank_pkg::K_LO;
              end
              sensor_bank_pkg::K_LO: begin
                // whole word here, commit only programmable bits
                if (wi != sensor_bank_pkg::NO_REG) begin
                  next_q.regs[wi] = {q.hold, q.sh}
                                    & sensor_bank_pkg::REG_WM[wi]; // R5 R17
                end
                next_q.raddr = q.raddr + 8'h01; // R6
                next_q.kind = sensor_bank_pkg::K_HI;
              end
            endcase
          end
        end
        sensor_bank_pkg::D_ACK: begin
          if (fall) begin
            next_q.sda_oe = 1'b0; // R16
            next_q.st = q.rd ? sensor_bank_pkg::D_TX
                             : sensor_bank_pkg::D_RX;
          end
        end
        sensor_bank_pkg::D_TX: begin
          if (fall) begin
            if (q.cnt == sensor_bank_pkg::LAST_BIT) begin
              // release for the master's acknowledge
              next_q.sda_oe = 1'b0; // R16
              next_q.st = sensor_bank_pkg::D_MACK;
            end else begin
              next_q.cnt = q.cnt + 4'h1;
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.sda_oe = !q.sh[6];
            end
          end
        end
        sensor_bank_pkg::D_MACK: begin
          if (rise && sda_s) begin
            // no acknowledge: read is over
            next_q.st = sensor_bank_pkg::D_IDLE; // R1
          end else if (fall) begin
            next_q.st = sensor_bank_pkg::D_TX;
          end
        end
      endcase
    end
    // a byte to send is loaded when entering transmit
    if (next_q.st == sensor_bank_pkg::D_TX &&
        q.st != sensor_bank_pkg::D_TX) begin
      next_q.cnt = 4'h0;
      if (q.kind == sensor_bank_pkg::K_HI) begin
        next_q.sh = word[15:8]; // R3
        next_q.kind = sensor_bank_pkg::K_LO;
      end else begin
        next_q.sh = word[7:0];
        next_q.kind = sensor_bank_pkg::K_HI;
        next_q.raddr = q.raddr + 8'h01; // R6
      end
      next_q.sda_oe = !next_q.sh[7];
    end
    // internal dark-level calibration loads its offsets
    if (cal_write) begin
      next_q.regs[ci] = {7'h00, cal_value}
                        & sensor_bank_pkg::REG_WM[ci]; // R13
    end
    next_q.busy = next_q.st != sensor_bank_pkg::D_IDLE;
  end

  // state register, defaults on reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q.st <= sensor_bank_pkg::D_IDLE;
      q.kind <= sensor_bank_pkg::K_DEV;
      q.rd <= 1'b0;
      q.cnt <= 4'h0;
      q.sh <= 8'h00;
      q.raddr <= 8'h00;
      q.hold <= 8'h00;
      q.sda_oe <= 1'b0;
      q.ps <= 1'b1;
      q.pd <= 1'b1;
      q.busy <= 1'b0;
      for (int i = 0; i < sensor_bank_pkg::NREG; i++) begin
        q.regs[i] <= sensor_bank_pkg::REG_RST[i]
                     & sensor_bank_pkg::REG_WM[i]; // R9 R10 R11 R12 R13
      end
    end else begin
      q <= next_q;
    end
  end

  // open drain: only ever drives low
  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = q.sda_oe;
  assign config_regs = q.regs;
  assign busy = q.busy;
endmodule : sensor_serial_register_bank
`default_nettype wire

// *** logic/two_flop_sync.sv ***
// two flip-flop synchroniser for pin inputs, idle high
`timescale 1ns/10ps
`default_nettype none
module two_flop_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta; // first stage, read by second only
    logic [W-1:0] stab; // second stage
  } sync_t;
  sync_t r, next_r;

  // shift the pin value through both stages
  always_comb begin
    next_r = r;
    next_r.meta = d;
    next_r.stab = r.meta;
  end

  // bus lines idle high, so reset to ones
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.stab;
endmodule : two_flop_sync
`default_nettype wire

// *** tb/sensor_link_props.sv ***
// concurrent checks on the two-wire link between master and register bank
`timescale 1ns/10ps
`default_nettype none
module sensor_link_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic host_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic serial_data_line
);
  // one domain: every check on the system clock, quiet during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // open drain: a driver may only ever pull low
  a_drive_low_only: assert property (!host_sda_out && !dev_sda_out)
    else $error("link driver drove a high level");
  // every start is followed by the device acknowledging its address
  a_addr_acked: assert property ((scl && $past(scl)
    && $fell(serial_data_line)) |-> ##[120:150] $rose(dev_sda_oe))
    else $error("device did not acknowledge its address");
  // device takes the line only while the clock is low
  a_dev_take_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device took the line with clock high");
  // device lets go only while the clock is low
  a_dev_free_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released the line with clock high");
  // a pulled level must still stand in some clock-high cycle within 20 cycles
  a_dev_seen_high: assert property ($rose(dev_sda_oe) |->
    ##[1:20] (scl && dev_sda_oe))
    else $error("device pull not held into clock high");
  // both ends pulling is allowed only in the low phase of a hand-over
  a_share_low: assert property ((host_sda_oe && dev_sda_oe) |-> !scl)
    else $error("both ends pulling with clock high");
  // a data edge under a high clock is a start or stop, master only
  a_high_host_only: assert property ((scl && $past(scl)
    && $changed(serial_data_line)) |-> $changed(host_sda_oe))
    else $error("line moved under high clock without the master");
  // for eight cycles after a stop the device stays off the line
  a_stop_dev_quiet: assert property ((scl && $past(scl)
    && $rose(serial_data_line)) |=> !dev_sda_oe [*8])
    else $error("device drove the line after a stop");
  // sized for a four-cycle quarter: ack plus eight low bits fits in 200
  a_dev_hold_bound: assert property (dev_sda_oe |->
    ##[1:200] !dev_sda_oe)
    else $error("device held the line too long");
endmodule : sensor_link_props
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench: master and register bank joined over the link
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] addr = 2'h0; // host register select
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic cal_write = 1'b0; // calibration load strobe
  logic [1:0] cal_sel = 2'h0;
  logic [8:0] cal_value = 9'h000;
  logic [sensor_bank_pkg::NREG-1:0][15:0] config_regs;
  logic busy;
  int n_fail = 0;
  int tests_run = 0;
  sensor_link_if link ();
  // short quarter keeps each serial transfer to a few hundred cycles
  sensor_bus_master #(.QUARTER_CYC(4)) sensor_bus_master_i (.clk(clk),
    .resetn(resetn), .link(link), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  sensor_serial_register_bank sensor_serial_register_bank_i (.clk(clk),
    .resetn(resetn), .link(link), .cal_write(cal_write),
    .cal_sel(cal_sel), .cal_value(cal_value),
    .config_regs(config_regs), .busy(busy));
  sensor_link_props sensor_link_props_i (.clk(clk), .resetn(resetn),
    .scl(link.scl), .host_sda_out(link.host_sda_out),
    .host_sda_oe(link.host_sda_oe), .dev_sda_out(link.dev_sda_out),
    .dev_sda_oe(link.dev_sda_oe),
    .serial_data_line(link.serial_data_line));
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle host port strobes
  task automatic hw(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : hw
  task automatic hr(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // read data stand only in this cycle: take them mid-cycle
    @(negedge clk);
    d = rdata;
  endtask : hr
  // one serial word transfer, waits for idle, checks the ack status
  task automatic op(input logic [7:0] r, input logic w,
                    input logic [15:0] d, output logic [15:0] q);
    logic [15:0] st;
    int n;
    logic seen; // device reported a transfer in progress
    n = 0;
    seen = 1'b0;
    hw(sensor_bank_pkg::HOST_WDATA, d);
    hw(sensor_bank_pkg::HOST_CMD, {r, 6'h00, !w, w});
    do begin
      hr(sensor_bank_pkg::HOST_STATUS, st);
      seen = seen | (busy === 1'b1);
      n++;
    end while (st[0] !== 1'b0 && n < 3000);
    chk("ack status", {14'h0000, st[1:0]}, 16'h0000);
    chk("device busy", {15'h0000, seen}, 16'h0001);
    if (!w) begin
      hr(sensor_bank_pkg::HOST_RDATA, q);
    end
  endtask : op
  task automatic rdchk(input logic [7:0] r, input logic [15:0] exp);
    logic [15:0] q;
    op(r, 1'b0, 16'h0000, q);
    chk("read word", q, exp);
  endtask : rdchk
  task automatic wr_word(input logic [7:0] r, input logic [15:0] d);
    logic [15:0] q;
    op(r, 1'b1, d, q);
  endtask : wr_word
  task automatic t_defaults;
    rdchk(8'h00, sensor_bank_pkg::CHIP_ID);
    rdchk(8'h01, 16'h000C);
    rdchk(8'h02, 16'h0014);
    rdchk(8'h03, 16'h03FF);
    rdchk(8'h04, 16'h04FF);
    rdchk(8'h60, 16'h0000);
  endtask : t_defaults
  // writes land only in programmable bits, both bytes in order
  task automatic t_write;
    wr_word(8'h03, 16'hFFFF);
    rdchk(8'h03, 16'h07FF);
    chk("height slot", config_regs[3], 16'h07FF);
    wr_word(8'h04, 16'h0103);
    rdchk(8'h04, 16'h0103);
    wr_word(8'h1E, 16'h0000);
    rdchk(8'h1E, 16'h8000);
    wr_word(8'h20, 16'h0000);
    rdchk(8'h20, 16'h1104);
  endtask : t_write
  // read-only id and holes in the map
  task automatic t_protect;
    wr_word(8'h00, 16'h1234);
    rdchk(8'h00, sensor_bank_pkg::CHIP_ID);
    wr_word(8'h08, 16'hFFFF);
    rdchk(8'h08, 16'h0000);
    rdchk(8'h09, 16'h0419);
  endtask : t_protect
  // every calibration target loaded from the side port
  task automatic t_cal;
    logic [7:0] offs [4];
    offs = '{8'h60, 8'h61, 8'h63, 8'h64};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cal_sel <= 2'(i);
      cal_value <= 9'h1A0 + 9'(i);
      cal_write <= 1'b1;
      @(posedge clk);
      cal_write <= 1'b0;
      rdchk(offs[i], 16'h01A0 + 16'(i));
    end
  endtask : t_cal
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_defaults();
    t_write();
    t_protect();
    t_cal();
    chk("busy idle", {15'h0000, busy}, 16'h0000);
    complete_run();
  end
  // watchdog: the tests need well under 60000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
